// ### hdl/twb_dev.sv
`timescale 1ns/1ps
module twb_dev import twb_pkg::*; #(
  parameter int DIVW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bus lines
  twb_if.dev bus,
  // configuration
  input wire logic [3:0] protocol_mode_field,
  input wire logic two_wire_capability_flag,
  input wire logic rate_fast,
  input wire logic slv_ack,
  // master commands
  input wire logic cmd_valid,
  input twb_cmd_t cmd_code,
  input wire logic cmd_read,
  input wire logic cmd_ack,
  output logic cmd_ready,
  // transmit data
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // receive data
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_ack,
  output logic rx_first,
  // status
  output logic bus_busy,
  output logic is_master,
  output logic slave_active,
  output logic arb_lost
);
  logic data_input_stage, clock_input_stage, en;
  logic sda_q_reg, scl_q_reg, busy_reg;
  logic start_det, stop_det, bus_idle, scl_rise, scl_fall;
  twb_mst_t m_state_reg;
  logic [4:0] q_reg, nq, half, q3;
  logic [8:0] m_sh_reg, m_rx_reg;
  logic [3:0] m_bit_reg;
  logic m_sda_reg, m_scl_reg, m_wr_reg, m_first_reg;
  logic tick, adv, m_fire, m_own, m_lost, m_done;
  logic s_act_reg, s_tx_reg, s_first_reg, s_sda_reg, s_hold_reg, s_ackd_reg, s_go_reg;
  logic [3:0] s_cnt_reg;
  logic [7:0] s_sh_reg, s_txd_reg;
  logic s_run, s_load, s_done;

  assign data_input_stage = bus.sda;
  assign clock_input_stage = bus.scl;
  assign en = (protocol_mode_field == MODE_TWB) && two_wire_capability_flag;

  // open-drain outputs: only ever pull low
  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_scl_out = 1'b0;
  assign bus.dev_sda_oe = m_sda_reg | s_sda_reg;
  assign bus.dev_scl_oe = m_scl_reg | s_hold_reg;

  // bus monitor
  assign start_det = scl_q_reg & clock_input_stage & sda_q_reg & ~data_input_stage;
  assign stop_det = scl_q_reg & clock_input_stage & ~sda_q_reg & data_input_stage;
  assign scl_rise = ~scl_q_reg & clock_input_stage;
  assign scl_fall = scl_q_reg & ~clock_input_stage;
  assign bus_idle = ~busy_reg & data_input_stage & clock_input_stage;
  assign bus_busy = busy_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_q_reg <= 1'b1;
      scl_q_reg <= 1'b1;
    end else begin
      sda_q_reg <= data_input_stage;
      scl_q_reg <= clock_input_stage;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
    end else if (!en || stop_det) begin
      busy_reg <= 1'b0;
    end else if (start_det) begin
      busy_reg <= 1'b1;
    end
  end

  // symbol timing
  assign nq = rate_fast ? NQ_FAST : NQ_STD;
  assign half = {1'b0, nq[4:1]};
  assign q3 = half + {2'b00, nq[4:2]};

  twb_quanta #(.DIVW(DIVW)) u_quanta (
    .clk(clk),
    .reset_n(reset_n),
    .run(en && (m_state_reg != M_IDLE)),
    .div(rate_fast ? DIVW'(TQ_FAST_DIV) : DIVW'(TQ_STD_DIV)),
    .tick(tick)
  );

  if (DIVW < 5) begin : g_chk
    $error("twb_dev: DIVW cannot hold the quantum divider");
  end

  // hold the quantum count while another party stretches the clock
  assign adv = tick && !((q_reg > half) && !clock_input_stage);

  always_comb begin
    cmd_ready = 1'b0;
    if (en && m_state_reg == M_IDLE) begin
      cmd_ready = (cmd_code == CMD_START) && bus_idle && !s_act_reg;
    end else if (en && m_state_reg == M_WAIT) begin
      cmd_ready = (cmd_code != CMD_XFER) || cmd_read || tx_valid;
    end
  end

  assign m_fire = cmd_valid && cmd_ready;
  assign m_own = m_wr_reg ? (m_bit_reg != ACK_IDX) : (m_bit_reg == ACK_IDX);
  assign m_lost = adv && (m_state_reg == M_BIT) && (q_reg == q3) && m_own &&
    m_sh_reg[8] && !data_input_stage;
  assign m_done = adv && (m_state_reg == M_BIT) && (q_reg == nq - 5'h01) &&
    (m_bit_reg == ACK_IDX);
  assign is_master = (m_state_reg != M_IDLE);

  // master symbol engine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      m_state_reg <= M_IDLE;
      q_reg <= 5'h00;
      m_sh_reg <= 9'h000;
      m_rx_reg <= 9'h000;
      m_bit_reg <= 4'h0;
      m_sda_reg <= 1'b0;
      m_scl_reg <= 1'b0;
      m_wr_reg <= 1'b0;
      m_first_reg <= 1'b0;
    end else if (!en || m_lost) begin
      m_state_reg <= M_IDLE;
      q_reg <= 5'h00;
      m_sda_reg <= 1'b0;
      m_scl_reg <= 1'b0;
    end else begin
      if (adv) begin
        q_reg <= (q_reg == nq - 5'h01) ? 5'h00 : q_reg + 5'h01;
      end
      case (m_state_reg)
        M_IDLE: begin
          if (m_fire) begin
            m_state_reg <= M_START;
            q_reg <= 5'h00;
            m_first_reg <= 1'b1;
          end
        end
        M_WAIT: begin
          if (m_fire) begin
            q_reg <= 5'h00;
            case (cmd_code)
              CMD_START: begin
                m_state_reg <= M_START;
                m_first_reg <= 1'b1;
              end
              CMD_XFER: begin
                m_state_reg <= M_BIT;
                m_bit_reg <= 4'h0;
                m_wr_reg <= !cmd_read;
                m_sh_reg <= cmd_read ? {8'hff, !cmd_ack} : {tx_data, 1'b1};
              end
              default: begin
                m_state_reg <= M_STOP;
              end
            endcase
          end
        end
        M_START: begin
          if (adv) begin
            if (q_reg == 5'h00) m_sda_reg <= 1'b0;
            if (q_reg == half) m_scl_reg <= 1'b0;
            if (q_reg == q3) m_sda_reg <= 1'b1;
            if (q_reg == nq - 5'h01) begin
              m_scl_reg <= 1'b1;
              m_state_reg <= M_WAIT;
            end
          end
        end
        M_BIT: begin
          if (adv) begin
            if (q_reg == 5'h00) m_sda_reg <= !m_sh_reg[8];
            if (q_reg == half) m_scl_reg <= 1'b0;
            if (q_reg == q3) m_rx_reg <= {m_rx_reg[7:0], data_input_stage};
            if (q_reg == nq - 5'h01) begin
              m_scl_reg <= 1'b1;
              m_sh_reg <= {m_sh_reg[7:0], 1'b1};
              if (m_bit_reg == ACK_IDX) begin
                m_state_reg <= M_WAIT;
                m_first_reg <= 1'b0;
              end else begin
                m_bit_reg <= m_bit_reg + 4'h1;
              end
            end
          end
        end
        M_STOP: begin
          if (adv) begin
            if (q_reg == 5'h00) m_sda_reg <= 1'b1;
            if (q_reg == half) m_scl_reg <= 1'b0;
            if (q_reg == q3) m_sda_reg <= 1'b0;
            if (q_reg == nq - 5'h01) m_state_reg <= M_IDLE;
          end
        end
        default: begin
          m_state_reg <= M_IDLE;
        end
      endcase
    end
  end

  // slave engine, stepped on sampled edges of the external clock line
  assign s_run = en && (m_state_reg == M_IDLE) && s_act_reg;
  assign s_load = s_run && s_tx_reg && tx_valid &&
    ((s_hold_reg && !s_go_reg) || (scl_fall && s_cnt_reg == 4'h0));
  assign s_done = s_run && scl_rise && (s_cnt_reg == ACK_IDX);
  assign tx_ready = (m_fire && (cmd_code == CMD_XFER) && !cmd_read) || s_load;
  assign slave_active = s_act_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_act_reg <= 1'b0;
      s_tx_reg <= 1'b0;
      s_first_reg <= 1'b0;
      s_sda_reg <= 1'b0;
      s_hold_reg <= 1'b0;
      s_ackd_reg <= 1'b0;
      s_go_reg <= 1'b0;
      s_cnt_reg <= 4'h0;
      s_sh_reg <= 8'h00;
      s_txd_reg <= 8'h00;
    end else if (!en || m_state_reg != M_IDLE || stop_det) begin
      s_act_reg <= 1'b0;
      s_sda_reg <= 1'b0;
      s_hold_reg <= 1'b0;
      s_go_reg <= 1'b0;
    end else if (start_det) begin
      s_act_reg <= 1'b1;
      s_tx_reg <= 1'b0;
      s_first_reg <= 1'b1;
      s_cnt_reg <= 4'h0;
      s_sda_reg <= 1'b0;
      s_hold_reg <= 1'b0;
      s_go_reg <= 1'b0;
    end else if (s_act_reg) begin
      if (scl_rise) begin
        if (s_cnt_reg == ACK_IDX) begin
          s_cnt_reg <= 4'h0;
          s_first_reg <= 1'b0;
          if (s_first_reg && s_ackd_reg) s_tx_reg <= s_sh_reg[0];
          if ((s_first_reg && !s_ackd_reg) || (s_tx_reg && data_input_stage)) begin
            s_act_reg <= 1'b0;
            s_sda_reg <= 1'b0;
          end
        end else begin
          s_sh_reg <= {s_sh_reg[6:0], data_input_stage};
          s_cnt_reg <= s_cnt_reg + 4'h1;
        end
      end
      if (scl_fall) begin
        if (s_cnt_reg == ACK_IDX) begin
          s_sda_reg <= !s_tx_reg && slv_ack;
          s_ackd_reg <= slv_ack;
        end else if (s_tx_reg && s_cnt_reg == 4'h0) begin
          s_hold_reg <= !tx_valid;
          s_sda_reg <= tx_valid && !tx_data[7];
          s_txd_reg <= tx_data;
        end else if (s_tx_reg) begin
          s_sda_reg <= !s_txd_reg[6];
          s_txd_reg <= {s_txd_reg[6:0], 1'b0};
        end else begin
          s_sda_reg <= 1'b0;
        end
      end else if (s_hold_reg && s_go_reg) begin
        // data has settled a cycle ago, now let the clock go
        s_hold_reg <= 1'b0;
        s_go_reg <= 1'b0;
      end else if (s_hold_reg && tx_valid) begin
        s_go_reg <= 1'b1;
        s_sda_reg <= !tx_data[7];
        s_txd_reg <= tx_data;
      end
    end
  end

  // receive reporting
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_ack <= 1'b0;
      rx_first <= 1'b0;
      arb_lost <= 1'b0;
    end else begin
      rx_valid <= m_done || s_done;
      arb_lost <= m_lost;
      if (m_done) begin
        rx_data <= m_rx_reg[8:1];
        rx_ack <= m_rx_reg[0];
        rx_first <= m_first_reg;
      end else if (s_done) begin
        rx_data <= s_sh_reg;
        rx_ack <= data_input_stage;
        rx_first <= s_first_reg;
      end
    end
  end
endmodule

// ### hdl/twb_pkg.sv
package twb_pkg;
  // module clock and bit rates
  localparam int CLK_NS = 25;
  localparam int BIT_STD_NS = 10000;
  localparam int BIT_FAST_NS = 2500;
  // quanta per symbol
  localparam logic [4:0] NQ_STD = 5'h19;
  localparam logic [4:0] NQ_FAST = 5'h0a;
  // cycles per time quantum, rounded up
  localparam int TQ_STD_CYC = (BIT_STD_NS + int'(NQ_STD) * CLK_NS - 1) / (int'(NQ_STD) * CLK_NS);
  localparam int TQ_FAST_CYC = (BIT_FAST_NS + int'(NQ_FAST) * CLK_NS - 1) / (int'(NQ_FAST) * CLK_NS);
  localparam logic [7:0] TQ_STD_DIV = 8'(TQ_STD_CYC);
  localparam logic [7:0] TQ_FAST_DIV = 8'(TQ_FAST_CYC);
  // far end: four phases per bit at standard rate
  localparam int FAR_PHASES = 4;
  localparam int FAR_Q_CYC = (BIT_STD_NS + FAR_PHASES * CLK_NS - 1) / (FAR_PHASES * CLK_NS);
  // mode code and word layout
  localparam logic [3:0] MODE_TWB = 4'h4;
  localparam logic [3:0] ACK_IDX = 4'h8;
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_XFER = 2'h1,
    CMD_STOP = 2'h2
  } twb_cmd_t;
  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_WAIT = 3'h3,
    M_BIT = 3'h2,
    M_STOP = 3'h6
  } twb_mst_t;
endpackage

// ### hdl/twb_if.sv
`timescale 1ns/1ps
interface twb_if;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic dev_scl_out;
  logic dev_scl_oe;
  logic far_sda_out;
  logic far_sda_oe;
  logic far_scl_out;
  logic far_scl_oe;
  logic sda;
  logic scl;
  // wired-and with pull-up
  assign sda = (dev_sda_oe ? dev_sda_out : 1'b1) & (far_sda_oe ? far_sda_out : 1'b1);
  assign scl = (dev_scl_oe ? dev_scl_out : 1'b1) & (far_scl_oe ? far_scl_out : 1'b1);
  modport dev (input sda, input scl, output dev_sda_out, output dev_sda_oe,
    output dev_scl_out, output dev_scl_oe);
  modport far (input sda, input scl, output far_sda_out, output far_sda_oe,
    output far_scl_out, output far_scl_oe);
endinterface

// ### hdl/twb_quanta.sv
`timescale 1ns/1ps
module twb_quanta #(
  parameter int DIVW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic [DIVW-1:0] div,
  // quantum pulse
  output logic tick
);
  logic [DIVW-1:0] cnt_reg;

  if (DIVW < 2) begin : g_chk
    $error("twb_quanta: DIVW too small");
  end

  assign tick = run && (cnt_reg == div - DIVW'(1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
    end else if (!run || tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + DIVW'(1);
    end
  end
endmodule

// ### hdl/twb_far.sv
`timescale 1ns/1ps
module twb_far import twb_pkg::*; #(
  parameter int QDIV = FAR_Q_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bus lines
  twb_if.far bus,
  // master commands
  input wire logic cmd_valid,
  input twb_cmd_t cmd_code,
  input wire logic cmd_read,
  input wire logic cmd_ack,
  input wire logic [7:0] tx_data,
  output logic cmd_ready,
  // receive data
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_ack
);
  twb_mst_t f_state_reg;
  logic [1:0] ph_reg;
  logic [8:0] f_sh_reg, f_rx_reg;
  logic [3:0] f_bit_reg;
  logic f_sda_reg, f_scl_reg, tick, adv;

  if (QDIV < 2 || QDIV > 255) begin : g_chk
    $error("twb_far: QDIV out of range");
  end

  assign bus.far_sda_out = 1'b0;
  assign bus.far_scl_out = 1'b0;
  assign bus.far_sda_oe = f_sda_reg;
  assign bus.far_scl_oe = f_scl_reg;

  twb_quanta #(.DIVW(8)) u_quanta (
    .clk(clk),
    .reset_n(reset_n),
    .run(f_state_reg != M_IDLE),
    .div(8'(QDIV)),
    .tick(tick)
  );

  // far end supplies the clock and waits out any stretch
  assign adv = tick && !(ph_reg[1] && !bus.scl);
  assign cmd_ready = (f_state_reg == M_WAIT) ||
    ((f_state_reg == M_IDLE) && (cmd_code == CMD_START) && bus.sda && bus.scl);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      f_state_reg <= M_IDLE;
      ph_reg <= 2'h0;
      f_sh_reg <= 9'h000;
      f_rx_reg <= 9'h000;
      f_bit_reg <= 4'h0;
      f_sda_reg <= 1'b0;
      f_scl_reg <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_ack <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (adv) ph_reg <= ph_reg + 2'h1;
      case (f_state_reg)
        M_IDLE, M_WAIT: begin
          if (cmd_valid && cmd_ready) begin
            ph_reg <= 2'h0;
            f_bit_reg <= 4'h0;
            f_sh_reg <= cmd_read ? {8'hff, !cmd_ack} : {tx_data, 1'b1};
            case (cmd_code)
              CMD_START: f_state_reg <= M_START;
              CMD_XFER: f_state_reg <= M_BIT;
              default: f_state_reg <= M_STOP;
            endcase
          end
        end
        M_START: begin
          if (adv) begin
            case (ph_reg)
              2'h0: f_sda_reg <= 1'b0;
              2'h1: f_scl_reg <= 1'b0;
              2'h2: f_sda_reg <= 1'b1;
              default: begin
                f_scl_reg <= 1'b1;
                f_state_reg <= M_WAIT;
              end
            endcase
          end
        end
        M_BIT: begin
          if (adv) begin
            case (ph_reg)
              2'h0: f_sda_reg <= !f_sh_reg[8];
              2'h1: f_scl_reg <= 1'b0;
              2'h2: f_rx_reg <= {f_rx_reg[7:0], bus.sda};
              default: begin
                f_scl_reg <= 1'b1;
                f_sh_reg <= {f_sh_reg[7:0], 1'b1};
                f_bit_reg <= f_bit_reg + 4'h1;
                if (f_bit_reg == ACK_IDX) begin
                  f_state_reg <= M_WAIT;
                  rx_valid <= 1'b1;
                  rx_data <= f_rx_reg[8:1];
                  rx_ack <= f_rx_reg[0];
                end
              end
            endcase
          end
        end
        M_STOP: begin
          if (adv) begin
            case (ph_reg)
              2'h0: f_sda_reg <= 1'b1;
              2'h1: f_scl_reg <= 1'b0;
              2'h2: f_sda_reg <= 1'b0;
              default: f_state_reg <= M_IDLE;
            endcase
          end
        end
        default: begin
          f_state_reg <= M_IDLE;
        end
      endcase
    end
  end
endmodule

// ### verification/twb_props.sv
`timescale 1ns/1ps
module twb_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // device end
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic dev_scl_out,
  input wire logic dev_scl_oe,
  // far end
  input wire logic far_sda_out,
  input wire logic far_sda_oe,
  input wire logic far_scl_out,
  input wire logic far_scl_oe,
  // resolved lines
  input wire logic sda,
  input wire logic scl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_dev_sda_od: assert property (dev_sda_out == 1'b0)
    else $error("device data line driven high");
  a_dev_scl_od: assert property (dev_scl_out == 1'b0)
    else $error("device clock line driven high");
  a_far_sda_od: assert property (far_sda_out == 1'b0)
    else $error("far data line driven high");
  a_far_scl_od: assert property (far_scl_out == 1'b0)
    else $error("far clock line driven high");
  a_sda_wired_and: assert property (sda == !(dev_sda_oe || far_sda_oe))
    else $error("data line level wrong");
  a_scl_wired_and: assert property (scl == !(dev_scl_oe || far_scl_oe))
    else $error("clock line level wrong");
  a_scl_high_min: assert property ($fell(dev_scl_oe) && !far_scl_oe |=> scl [*4])
    else $error("clock high phase too short");
  a_start_scl_held: assert property ($rose(dev_sda_oe) && scl |-> !dev_scl_oe [*4])
    else $error("clock pulled during start");
  a_stop_idle_hold: assert property ($fell(dev_sda_oe) && scl && !far_sda_oe |=> sda [*8])
    else $error("data line not idle after stop");
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import twb_pkg::*;
  logic clk, reset_n, cap, rate_fast, slv_ack, tx_valid, tx_ready;
  logic [3:0] mode;
  logic d_cv, d_rd, d_ack, d_rdy, d_rxv, d_rxa, d_rxf, bus_busy, is_master, slave_active, arb_lost;
  logic f_cv, f_rd, f_ack, f_rdy, f_rxv, f_rxa;
  logic [7:0] tx_data, d_rxd, f_txd, f_rxd, a, b;
  logic [8:0] wsh;
  twb_cmd_t d_code, f_code;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int wcnt = 0;
  int last_rise = 0;
  int last_per = 0;
  logic [15:0] dq[$], fq[$], wexp[$], wobs[$];
  twb_if bus ();
  twb_dev u_twb_dev (.clk(clk), .reset_n(reset_n), .bus(bus), .protocol_mode_field(mode),
    .two_wire_capability_flag(cap), .rate_fast(rate_fast), .slv_ack(slv_ack),
    .cmd_valid(d_cv), .cmd_code(d_code), .cmd_read(d_rd), .cmd_ack(d_ack), .cmd_ready(d_rdy),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(d_rxv),
    .rx_data(d_rxd), .rx_ack(d_rxa), .rx_first(d_rxf), .bus_busy(bus_busy),
    .is_master(is_master), .slave_active(slave_active), .arb_lost(arb_lost));
  twb_far #(.QDIV(4)) u_twb_far (.clk(clk), .reset_n(reset_n), .bus(bus), .cmd_valid(f_cv),
    .cmd_code(f_code), .cmd_read(f_rd), .cmd_ack(f_ack), .tx_data(f_txd), .cmd_ready(f_rdy),
    .rx_valid(f_rxv), .rx_data(f_rxd), .rx_ack(f_rxa));
  twb_props u_twb_props (.clk(clk), .reset_n(reset_n), .dev_sda_out(bus.dev_sda_out),
    .dev_sda_oe(bus.dev_sda_oe), .dev_scl_out(bus.dev_scl_out), .dev_scl_oe(bus.dev_scl_oe),
    .far_sda_out(bus.far_sda_out), .far_sda_oe(bus.far_sda_oe),
    .far_scl_out(bus.far_scl_out), .far_scl_oe(bus.far_scl_oe), .sda(bus.sda), .scl(bus.scl));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one command on the device (sel=1) or far end, held until accepted
  task automatic cmd(input bit sel, input twb_cmd_t c, input logic rd, input logic [7:0] d);
    int n;
    n = 0;
    #1;
    if (sel) begin
      d_cv = 1'b1; d_code = c; d_rd = rd; d_ack = 1'b0;
      if (c == CMD_XFER && !rd) begin
        tx_data = d; tx_valid = 1'b1;
      end
    end else begin
      f_cv = 1'b1; f_code = c; f_rd = rd; f_ack = 1'b0; f_txd = d;
    end
    @(posedge clk);
    while ((sel ? d_rdy : f_rdy) !== 1'b1 && n < 9000) begin
      n++;
      @(posedge clk);
    end
    if (n >= 9000) check(16'h0, 16'h1);
    #1;
    if (sel) d_cv = 1'b0;
    else f_cv = 1'b0;
  endtask
  // waits: 0 far word, 1 device word, 2 bus released
  task automatic wt(input int w);
    int n;
    n = 0;
    @(posedge clk);
    while (!((w == 0 && f_rxv === 1'b1) || (w == 1 && d_rxv === 1'b1) ||
        (w == 2 && bus_busy === 1'b0 && is_master === 1'b0)) && n < 9000) begin
      n++;
      @(posedge clk);
    end
    if (n >= 9000) check(16'h0, 16'h2);
  endtask
  task automatic wire_cmp(input string name);
    check(16'(wobs.size()), 16'(wexp.size()));
    check(16'(dq.size() + fq.size()), 16'h0);
    while (wobs.size() > 0 && wexp.size() > 0) check(wobs.pop_front(), wexp.pop_front());
    wobs.delete();
    wexp.delete();
    $display("test %0s done", name);
  endtask
  always @(posedge clk) cyc++;
  always @(posedge clk) if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
    #1;
    tx_valid = 1'b0;
  end
  // word model against both user sides
  always @(posedge clk) begin
    if (d_rxv === 1'b1) check({6'h00, d_rxf, d_rxa, d_rxd}, dq.size() ? dq.pop_front() : 16'hffff);
    if (f_rxv === 1'b1) check({7'h00, f_rxa, f_rxd}, fq.size() ? fq.pop_front() : 16'hffff);
    if (d_rxv === 1'b1 || arb_lost !== 1'b0) check({15'h0, arb_lost}, 16'h0);
  end
  // wire monitor: bits taken at each clock rise, start restarts the word
  always @(posedge bus.scl) begin
    wsh = {wsh[7:0], bus.sda};
    wcnt++;
    if (wcnt >= 2) last_per = cyc - last_rise;
    last_rise = cyc;
    if (wcnt == 9) begin
      wobs.push_back({7'h00, wsh});
      wcnt = 0;
    end
  end
  always @(negedge bus.sda) if (bus.scl === 1'b1) wcnt = 0;
  initial begin
    #(25ns * 60000);
    n_errors++;
    print_verdict();
  end
  initial begin
    reset_n = 1'b0; mode = MODE_TWB; cap = 1'b1; rate_fast = 1'b1; slv_ack = 1'b1;
    tx_valid = 1'b0; tx_data = 8'h00; wsh = 9'h000;
    d_cv = 1'b0; d_code = CMD_START; d_rd = 1'b0; d_ack = 1'b0;
    f_cv = 1'b0; f_code = CMD_START; f_rd = 1'b0; f_ack = 1'b0; f_txd = 8'h00;
    void'($urandom(63));
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    // mode gating
    for (int m = 0; m < 17; m++) begin
      @(posedge clk);
      #1 mode = (m < 16) ? 4'(m) : MODE_TWB;
      cap = (m < 16);
      repeat (3) @(posedge clk);
      check({15'h0, d_rdy}, {15'h0, (m == 4)});
    end
    #1 cap = 1'b1;
    // device master at both rates, repeated start between the two written words
    for (int r = 1; r >= 0; r--) begin
      #1 rate_fast = r[0];
      a = 8'($urandom_range(255));
      b = 8'($urandom_range(255));
      dq.push_back({6'h00, 2'b11, a}); wexp.push_back({7'h00, a, 1'b1});
      dq.push_back({6'h00, 2'b11, b}); wexp.push_back({7'h00, b, 1'b1});
      cmd(1, CMD_START, 1'b0, 8'h00);
      cmd(1, CMD_XFER, 1'b0, a);
      wt(1);
      cmd(1, CMD_START, 1'b0, 8'h00);
      cmd(1, CMD_XFER, 1'b0, b);
      wt(1);
      check(16'(last_per), r ? 16'd100 : 16'd400);
      check({is_master, bus_busy}, 2'b11);
      dq.push_back({6'h00, 2'b01, 8'hff});
      wexp.push_back({7'h00, 8'hff, 1'b1});
      cmd(1, CMD_XFER, 1'b1, 8'h00);
      wt(1);
      cmd(1, CMD_STOP, 1'b0, 8'h00);
      wt(2);
      check({is_master, bus_busy}, 2'b00);
      wire_cmp("master");
    end
    // far master writes to device slave, acked then not acked
    for (int k = 1; k >= 0; k--) begin
      #1 slv_ack = k[0];
      a = 8'($urandom_range(255)) & 8'hfe;
      b = 8'($urandom_range(255));
      dq.push_back({6'h00, 1'b1, !k[0], a}); fq.push_back({7'h00, !k[0], a});
      wexp.push_back({7'h00, a, !k[0]});
      cmd(0, CMD_START, 1'b0, 8'h00);
      cmd(0, CMD_XFER, 1'b0, a);
      wt(0);
      check({15'h0, slave_active}, {15'h0, k[0]});
      if (k) begin
        dq.push_back({6'h00, 2'b00, b}); fq.push_back({8'h00, b}); wexp.push_back({7'h00, b, 1'b0});
        cmd(0, CMD_XFER, 1'b0, b);
        wt(0);
      end
      cmd(0, CMD_STOP, 1'b0, 8'h00);
      wt(2);
      wire_cmp("slave write");
    end
    // far master reads device slave, device stretches until data arrives
    #1 slv_ack = 1'b1;
    a = 8'($urandom_range(255)) | 8'h01;
    b = 8'($urandom_range(255));
    dq.push_back({6'h00, 2'b10, a}); fq.push_back({7'h00, 1'b0, a}); wexp.push_back({7'h00, a, 1'b0});
    dq.push_back({6'h00, 2'b01, b}); fq.push_back({7'h00, 1'b1, b}); wexp.push_back({7'h00, b, 1'b1});
    cmd(0, CMD_START, 1'b0, 8'h00);
    cmd(0, CMD_XFER, 1'b0, a);
    wt(0);
    cmd(0, CMD_XFER, 1'b1, 8'h00);
    repeat (40) @(posedge clk);
    check({14'h0, bus.scl, bus.dev_scl_oe}, 16'h1);
    #1 tx_data = b;
    tx_valid = 1'b1;
    wt(0);
    check({15'h0, tx_valid}, 16'h0);
    cmd(0, CMD_STOP, 1'b0, 8'h00);
    wt(2);
    check({15'h0, slave_active}, 16'h0);
    wire_cmp("slave read");
    print_verdict();
  end
endmodule
